// [cps_crossbar.v]
`include "cps_regs.vh"
`default_nettype none

module cps_crossbar #(
    parameter NPINS = 16
) (
    input wire mclk_i,                     // System clock, 25 MHz
    input wire resetn_i,                   // Synchronous reset, active low
    input wire [7:0] sfr_addr_i,           // Special-function address
    input wire [7:0] sfr_page_i,           // Selected special-function page
    input wire sfr_wr_i,                   // Write strobe, one cycle
    input wire [7:0] sfr_wdata_i,          // Write data
    output wire [7:0] sfr_rdata_o,         // Read data, one cycle after address
    output wire sfr_hit_o,                 // Address decoded, one cycle after address
    input wire crossbar_global_enable_i,   // Global crossbar enable level
    input wire [NPINS-1:0] skip_i,         // Pins skipped by the decoder
    input wire serial_periph_4wire_i,      // Serial peripheral uses its select line
    input wire [`CPS_NFUNC-1:0] periph_out_i, // Peripheral output values by function
    input wire [`CPS_NFUNC-1:0] periph_oe_i,  // Peripheral drive enables by function
    output wire [`CPS_NFUNC-1:0] periph_in_o, // Pin values back to peripherals
    input wire uart_transmit_out_i,        // UART transmit data
    output wire uart_receive_in_o,         // UART receive data, idle high
    input wire [NPINS-1:0] port_out_i,     // Standard port output values
    input wire [NPINS-1:0] port_oe_i,      // Standard port drive enables
    output wire [NPINS-1:0] port_in_o,     // Synchronised pin levels
    input wire [NPINS-1:0] pin_in_i,       // Pad input levels
    output wire [NPINS-1:0] pin_out_o,     // Pad output values
    output wire [NPINS-1:0] pin_oe_o,      // Pad output enables, high drives
    output wire [5*NPINS-1:0] pin_func_o,  // Per-pin function code map
    output wire [7:0] crossbar_select_a_o, // Current select A value
    output wire [7:0] crossbar_select_b_o  // Current select B value
);

    reg [7:0] crossbar_select_a_q;
    reg [7:0] crossbar_select_b_q;
    reg [7:0] rdata_q;
    reg hit_q;
    reg [`CPS_NFUNC-1:0] req_d;
    reg [`CPS_NFUNC-1:0] used_d;
    reg [`CPS_NFUNC-1:0] got_d;
    reg [5*NPINS-1:0] map_d;
    reg [5*NPINS-1:0] map_q;
    reg [NPINS-1:0] pin_out_q;
    reg [NPINS-1:0] pin_oe_q;
    reg [`CPS_NFUNC-1:0] periph_in_q;
    reg uart_rx_q;
    reg found_d;
    reg [2:0] chan_cnt_d;
    reg [4:0] code_d;
    wire [NPINS-1:0] pin_sync;
    wire page_ok;
    wire sel_a_hit;
    wire sel_b_hit;
    wire uart_en;
    integer p;
    integer f;
    integer fr;
    integer po;
    integer fo;

    // Pad inputs pass two flops before any use
    cps_sync #(
        .WIDTH(NPINS)
    ) u_pin_sync (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .async_i(pin_in_i),
        .sync_o(pin_sync)
    );

    // Address decode gated by the page
    assign page_ok = (sfr_page_i == `CPS_SEL_PAGE);
    assign sel_a_hit = page_ok && (sfr_addr_i == `CPS_SEL_A_ADDR);
    assign sel_b_hit = page_ok && (sfr_addr_i == `CPS_SEL_B_ADDR);

    // Register writes; select A bit 1 is read-only and never stored
    always @(posedge mclk_i) begin
        if (!resetn_i) begin
            crossbar_select_a_q <= `CPS_SEL_A_RESET;
            crossbar_select_b_q <= `CPS_SEL_B_RESET;
        end else if (sfr_wr_i) begin
            if (sel_a_hit) begin
                crossbar_select_a_q <= sfr_wdata_i & `CPS_SEL_A_WMASK;
            end
            if (sel_b_hit) begin
                crossbar_select_b_q <= sfr_wdata_i & `CPS_SEL_B_WMASK;
            end
        end
    end

    // Registered read port; unmapped addresses read zero
    always @(posedge mclk_i) begin
        if (!resetn_i) begin
            rdata_q <= 8'h00;
            hit_q <= 1'b0;
        end else begin
            hit_q <= sel_a_hit | sel_b_hit;
            if (sel_a_hit) begin
                rdata_q <= crossbar_select_a_q;
            end else if (sel_b_hit) begin
                rdata_q <= crossbar_select_b_q;
            end else begin
                rdata_q <= 8'h00;
            end
        end
    end

    assign uart_en = crossbar_select_a_q[`CPS_A_UART];

    // Requested functions in priority order
    always @* begin
        req_d = {`CPS_NFUNC{1'b0}};
        chan_cnt_d = crossbar_select_b_q[`CPS_B_CHAN_HI:`CPS_B_CHAN_LO];
        if (chan_cnt_d == `CPS_B_CHAN_RESERVED) begin
            chan_cnt_d = 3'h0;
        end
        req_d[`CPS_F_SCK] = crossbar_select_a_q[`CPS_A_SERIAL_PERIPH];
        req_d[`CPS_F_MISO] = crossbar_select_a_q[`CPS_A_SERIAL_PERIPH];
        req_d[`CPS_F_MOSI] = crossbar_select_a_q[`CPS_A_SERIAL_PERIPH];
        req_d[`CPS_F_NSS] = crossbar_select_a_q[`CPS_A_SERIAL_PERIPH]
            & serial_periph_4wire_i;
        req_d[`CPS_F_SDA] = crossbar_select_a_q[`CPS_A_TWOWIRE];
        req_d[`CPS_F_SCL] = crossbar_select_a_q[`CPS_A_TWOWIRE];
        req_d[`CPS_F_CP0] = crossbar_select_a_q[`CPS_A_CMP0_SYNC];
        req_d[`CPS_F_CP0A] = crossbar_select_a_q[`CPS_A_CMP0_ASYNC];
        req_d[`CPS_F_CP1] = crossbar_select_a_q[`CPS_A_CMP1_SYNC];
        req_d[`CPS_F_CP1A] = crossbar_select_a_q[`CPS_A_CMP1_ASYNC];
        req_d[`CPS_F_SYSCLK] = crossbar_select_b_q[`CPS_B_SYSCLK];
        for (fr = 0; fr < 6; fr = fr + 1) begin
            req_d[`CPS_F_COUNTER_CHANNEL_0_IO + fr] = (fr < chan_cnt_d);
        end
        req_d[`CPS_F_ECI] = crossbar_select_b_q[`CPS_B_COUNTER_CLK];
        req_d[`CPS_F_T0] = crossbar_select_b_q[`CPS_B_TIMER0];
        req_d[`CPS_F_T1] = crossbar_select_b_q[`CPS_B_TIMER1];
    end

    // Priority decoder: each free pin takes the highest unassigned request
    always @* begin
        map_d = {5*NPINS{1'b0}};
        used_d = {`CPS_NFUNC{1'b0}};
        got_d = {`CPS_NFUNC{1'b0}};
        found_d = 1'b0;
        code_d = `CPS_CODE_GPIO;
        if (crossbar_global_enable_i) begin
            for (p = 0; p < NPINS; p = p + 1) begin
                code_d = `CPS_CODE_GPIO;
                found_d = 1'b0;
                if (uart_en && p == `CPS_UART_TX_PIN) begin
                    code_d = `CPS_CODE_UART_TX;
                end else if (uart_en && p == `CPS_UART_RX_PIN) begin
                    code_d = `CPS_CODE_UART_RX;
                end else if (!skip_i[p]) begin
                    for (f = 0; f < `CPS_NFUNC; f = f + 1) begin
                        if (!found_d && req_d[f] && !used_d[f]) begin
                            found_d = 1'b1;
                            used_d[f] = 1'b1;
                            code_d = f[4:0] + 5'h01;
                        end
                    end
                end
                map_d[5*p +: 5] = code_d;
            end
            got_d = used_d;
            // Drop a lone two-wire signal when the pins ran out
            if (got_d[`CPS_F_SDA] && !got_d[`CPS_F_SCL]) begin
                for (p = 0; p < NPINS; p = p + 1) begin
                    if (map_d[5*p +: 5] == `CPS_F_SDA + 1) begin
                        map_d[5*p +: 5] = `CPS_CODE_GPIO;
                    end
                end
            end
        end
    end

    // Pad drive, peripheral inputs and the map all come from flops
    always @(posedge mclk_i) begin
        if (!resetn_i) begin
            map_q <= {5*NPINS{1'b0}};
            pin_out_q <= {NPINS{1'b0}};
            pin_oe_q <= {NPINS{1'b0}};
            periph_in_q <= {`CPS_NFUNC{1'b0}};
            uart_rx_q <= 1'b1;
        end else begin
            map_q <= map_d;
            for (po = 0; po < NPINS; po = po + 1) begin
                pin_out_q[po] <= port_out_i[po];
                pin_oe_q[po] <= port_oe_i[po] & crossbar_global_enable_i;
                for (fo = 0; fo < `CPS_NFUNC; fo = fo + 1) begin
                    if (map_d[5*po +: 5] == fo + 1) begin
                        pin_out_q[po] <= periph_out_i[fo];
                        pin_oe_q[po] <= periph_oe_i[fo];
                    end
                end
                if (map_d[5*po +: 5] == `CPS_CODE_UART_TX) begin
                    pin_out_q[po] <= uart_transmit_out_i;
                    pin_oe_q[po] <= 1'b1;
                end
                if (map_d[5*po +: 5] == `CPS_CODE_UART_RX) begin
                    pin_oe_q[po] <= 1'b0;
                end
            end
            uart_rx_q <= 1'b1;
            periph_in_q <= {`CPS_NFUNC{1'b0}};
            for (po = 0; po < NPINS; po = po + 1) begin
                for (fo = 0; fo < `CPS_NFUNC; fo = fo + 1) begin
                    if (map_d[5*po +: 5] == fo + 1) begin
                        periph_in_q[fo] <= pin_sync[po];
                    end
                end
                if (map_d[5*po +: 5] == `CPS_CODE_UART_RX) begin
                    uart_rx_q <= pin_sync[po];
                end
            end
        end
    end

    assign sfr_rdata_o = rdata_q;
    assign sfr_hit_o = hit_q;
    assign pin_out_o = pin_out_q;
    assign pin_oe_o = pin_oe_q;
    assign pin_func_o = map_q;
    assign periph_in_o = periph_in_q;
    assign uart_receive_in_o = uart_rx_q;
    assign port_in_o = pin_sync;
    assign crossbar_select_a_o = crossbar_select_a_q;
    assign crossbar_select_b_o = crossbar_select_b_q;

endmodule

`default_nettype wire

// [cps_crossbar_monitor.sv]
`default_nettype none
module cps_crossbar_monitor #(
    parameter int NPINS = 16
) (
    input wire logic mclk_i, // Clock
    input wire logic resetn_i, // Reset
    input wire logic [7:0] sfr_addr_i, // Address
    input wire logic [7:0] sfr_page_i, // Page
    input wire logic sfr_wr_i, // Write
    input wire logic [7:0] sfr_wdata_i, // Write data
    input wire logic [7:0] sfr_rdata_o, // Read data
    input wire logic sfr_hit_o, // Decode hit
    input wire logic crossbar_global_enable_i, // Enable
    input wire logic [NPINS-1:0] pin_oe_o, // Pad enables
    input wire logic [5*NPINS-1:0] pin_func_o, // Pin map
    input wire logic uart_receive_in_o, // UART receive
    input wire logic [7:0] crossbar_select_a_o, // Select A
    input wire logic [7:0] crossbar_select_b_o // Select B
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);
    // Decode of the two select registers on their page
    wire hit_a = sfr_page_i == 8'h0f && sfr_addr_i == 8'he1;
    wire hit_b = sfr_page_i == 8'h0f && sfr_addr_i == 8'he2;
    AST_WR_A: assert property (sfr_wr_i && hit_a |=>
        crossbar_select_a_o == ($past(sfr_wdata_i) & 8'hfd)) else $error("select a write lost");
    AST_WR_B: assert property (sfr_wr_i && hit_b |=>
        crossbar_select_b_o == $past(sfr_wdata_i)) else $error("select b write lost");
    AST_OFF_PAGE: assert property (sfr_wr_i && sfr_page_i != 8'h0f |=>
        $stable(crossbar_select_a_o) && $stable(crossbar_select_b_o))
        else $error("write off page changed a select");
    AST_HIT: assert property (hit_a || hit_b |=> sfr_hit_o) else $error("hit missing");
    AST_MISS: assert property (!(hit_a || hit_b) |=> !sfr_hit_o && sfr_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    AST_RD_A: assert property (hit_a && !sfr_wr_i |=> sfr_rdata_o == crossbar_select_a_o)
        else $error("select a read wrong");
    AST_A_RSV: assert property (crossbar_select_a_o[1] == 1'b0)
        else $error("reserved bit set");
    AST_OFF: assert property (!crossbar_global_enable_i |=>
        pin_oe_o == '0 && pin_func_o == '0) else $error("pins driven while disabled");
    AST_UART: assert property (crossbar_global_enable_i && crossbar_select_a_o[0] |=>
        pin_func_o[24:20] == 5'h15 && pin_func_o[29:25] == 5'h16) else $error("uart pins wrong");
    AST_URX: assert property (!crossbar_select_a_o[0] |=> uart_receive_in_o)
        else $error("unrouted uart receive low");
endmodule
bind cps_crossbar cps_crossbar_monitor #(.NPINS(NPINS)) mon_u (.mclk_i, .resetn_i, .sfr_addr_i,
    .sfr_page_i, .sfr_wr_i, .sfr_wdata_i, .sfr_rdata_o, .sfr_hit_o, .crossbar_global_enable_i,
    .pin_oe_o, .pin_func_o, .uart_receive_in_o, .crossbar_select_a_o, .crossbar_select_b_o);
`default_nettype wire

// [cps_regs.vh]
`ifndef CPS_REGS_VH
`define CPS_REGS_VH

// Special-function addresses and page of the two select registers
`define CPS_SEL_A_ADDR 8'he1
`define CPS_SEL_B_ADDR 8'he2
`define CPS_SEL_PAGE 8'h0f

// Reset values and writable-bit masks
`define CPS_SEL_A_RESET 8'h00
`define CPS_SEL_B_RESET 8'h00
`define CPS_SEL_A_WMASK 8'hfd
`define CPS_SEL_B_WMASK 8'hff

// Field positions in crossbar_select_a
`define CPS_A_CMP1_ASYNC 7
`define CPS_A_CMP1_SYNC 6
`define CPS_A_CMP0_ASYNC 5
`define CPS_A_CMP0_SYNC 4
`define CPS_A_TWOWIRE 3
`define CPS_A_SERIAL_PERIPH 2
`define CPS_A_UART 0

// Field positions in crossbar_select_b
`define CPS_B_TIMER1 7
`define CPS_B_TIMER0 6
`define CPS_B_COUNTER_CLK 5
`define CPS_B_CHAN_HI 4
`define CPS_B_CHAN_LO 2
`define CPS_B_SYSCLK 1
`define CPS_B_CHAN_RESERVED 3'h7

// Function indices in priority order (pin map code is index plus one)
`define CPS_F_SCK 0
`define CPS_F_MISO 1
`define CPS_F_MOSI 2
`define CPS_F_NSS 3
`define CPS_F_SDA 4
`define CPS_F_SCL 5
`define CPS_F_CP0 6
`define CPS_F_CP0A 7
`define CPS_F_CP1 8
`define CPS_F_CP1A 9
`define CPS_F_SYSCLK 10
`define CPS_F_COUNTER_CHANNEL_0_IO 11
`define CPS_F_ECI 17
`define CPS_F_T0 18
`define CPS_F_T1 19
`define CPS_NFUNC 20

// Pin map codes
`define CPS_CODE_GPIO 5'h00
`define CPS_CODE_UART_TX 5'h15
`define CPS_CODE_UART_RX 5'h16

// Fixed UART pin positions
`define CPS_UART_TX_PIN 4
`define CPS_UART_RX_PIN 5

`endif

// [cps_sync.v]
`default_nettype none

module cps_sync #(
    parameter WIDTH = 8
) (
    input wire mclk_i,              // System clock
    input wire resetn_i,            // Synchronous reset, active low
    input wire [WIDTH-1:0] async_i, // Level from outside the clock domain
    output wire [WIDTH-1:0] sync_o  // Level after two flops
);

    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    // Two-flop synchroniser; first stage feeds only the second
    always @(posedge mclk_i) begin
        if (!resetn_i) begin
            meta_q <= {WIDTH{1'b0}};
            sync_q <= {WIDTH{1'b0}};
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;

endmodule

`default_nettype wire

// [tb_crossbar_peripheral_select.sv]
`default_nettype none
module tb_crossbar_peripheral_select;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i, resetn_i, sfr_wr_i, sfr_hit_o, crossbar_global_enable_i;
    logic serial_periph_4wire_i, uart_transmit_out_i, uart_receive_in_o;
    logic [7:0] sfr_addr_i, sfr_page_i, sfr_wdata_i, sfr_rdata_o;
    logic [7:0] crossbar_select_a_o, crossbar_select_b_o;
    logic [19:0] periph_out_i, periph_oe_i, periph_in_o;
    logic [15:0] skip_i, port_out_i, port_oe_i, port_in_o, pin_in_i, pin_out_o, pin_oe_o;
    logic [79:0] pin_func_o, m;
    int fail_count, n_compared, i;
    integer seed;
    cps_crossbar #(.NPINS(16)) dut_u (.mclk_i, .resetn_i, .sfr_addr_i, .sfr_page_i, .sfr_wr_i,
        .sfr_wdata_i, .sfr_rdata_o, .sfr_hit_o, .crossbar_global_enable_i, .skip_i,
        .serial_periph_4wire_i, .periph_out_i, .periph_oe_i, .periph_in_o, .uart_transmit_out_i,
        .uart_receive_in_o, .port_out_i, .port_oe_i, .port_in_o, .pin_in_i, .pin_out_o,
        .pin_oe_o, .pin_func_o, .crossbar_select_a_o, .crossbar_select_b_o);
    // Clock at 25 MHz
    initial begin
        mclk_i = 1'b0;
        forever #20 mclk_i = ~mclk_i;
    end
    // Expected pin map from the selects, skips and wire mode
    function automatic logic [79:0] exp_map(input logic [7:0] a, b, input logic [15:0] sk,
        input logic w4);
        logic [19:0] e;
        logic [79:0] r;
        int p, n, sda;
        e = {b[7], b[6], b[5], 6'h00, b[1], a[7], a[6], a[5], a[4], a[3], a[3],
             a[2] & w4, a[2], a[2], a[2]};
        for (p = 0; p < 6; p++) e[11+p] = b[4:2] != 3'h7 && p < b[4:2];
        r = '0;
        n = 0;
        sda = -1;
        for (p = 0; p < 16; p++) begin
            if (a[0] && p == 4) r[24:20] = 5'h15;
            else if (a[0] && p == 5) r[29:25] = 5'h16;
            else if (!sk[p]) begin
                while (n < 20 && !e[n]) n++;
                if (n < 20) begin
                    r[5*p +: 5] = 5'(n + 1);
                    if (n == 4) sda = p;
                    n++;
                end
            end
        end
        if (sda >= 0 && n == 5) r[5*sda +: 5] = 5'h00;
        return r;
    endfunction
    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [79:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One write strobe held for one cycle, then released on return
    task automatic wr(input logic [7:0] pg, ad, d);
        @(negedge mclk_i);
        sfr_page_i = pg;
        sfr_addr_i = ad;
        sfr_wdata_i = d;
        sfr_wr_i = 1'b1;
        @(negedge mclk_i);
        sfr_wr_i = 1'b0;
    endtask
    task automatic rd(input logic [7:0] pg, ad, d, input logic h);
        @(negedge mclk_i);
        sfr_page_i = pg;
        sfr_addr_i = ad;
        @(negedge mclk_i);
        chk({h, sfr_rdata_o}, {h, d});
        chk(sfr_hit_o, h);
    endtask
    // Program both selects and compare the pin map and port pins
    task automatic apply(input logic [7:0] a, b, input logic [15:0] sk, input logic w4);
        logic [19:0] pi;
        logic [4:0] c;
        logic ur;
        skip_i = sk;
        serial_periph_4wire_i = w4;
        port_out_i = $random(seed);
        port_oe_i = $random(seed);
        pin_in_i = $random(seed);
        periph_out_i = $random(seed);
        uart_transmit_out_i = $random(seed);
        wr(8'h0f, 8'he1, a);
        wr(8'h0f, 8'he2, b);
        @(negedge mclk_i);
        m = crossbar_global_enable_i ? exp_map(a, b, sk, w4) : '0;
        pi = '0;
        ur = 1'b1;
        chk(pin_func_o, m);
        chk(port_in_o, pin_in_i);
        for (int p = 0; p < 16; p++) begin
            c = m[5*p +: 5];
            if (c == 5'h00 && crossbar_global_enable_i)
                chk({pin_oe_o[p], pin_out_o[p]}, {port_oe_i[p], port_out_i[p]});
            else if (!crossbar_global_enable_i) chk(pin_oe_o[p], 1'b0);
            else if (c == 5'h15)
                chk({pin_oe_o[p], pin_out_o[p]}, {1'b1, uart_transmit_out_i});
            else if (c == 5'h16) begin
                chk(pin_oe_o[p], 1'b0);
                ur = pin_in_i[p];
            end else begin
                chk({pin_oe_o[p], pin_out_o[p]}, {periph_oe_i[c-1], periph_out_i[c-1]});
                pi[c-1] = pin_in_i[p];
            end
        end
        chk(periph_in_o, pi);
        chk(uart_receive_in_o, ur);
    endtask
    // Watchdog
    initial begin
        #2ms;
        fail_count++;
        end_sim();
    end
    initial begin
        seed = 32'h17470461;
        {fail_count, n_compared} = '0;
        {resetn_i, sfr_wr_i, sfr_addr_i, sfr_page_i, sfr_wdata_i} = '0;
        {crossbar_global_enable_i, serial_periph_4wire_i, uart_transmit_out_i} = '0;
        {skip_i, port_out_i, port_oe_i, pin_in_i, periph_out_i, periph_oe_i} = '0;
        repeat (5) @(negedge mclk_i);
        resetn_i = 1'b1;
        rd(8'h0f, 8'he1, 8'h00, 1'b1);
        rd(8'h0f, 8'he2, 8'h00, 1'b1);
        wr(8'h0f, 8'he1, 8'hff);
        rd(8'h0f, 8'he1, 8'hfd, 1'b1);
        wr(8'h0f, 8'he2, 8'hff);
        rd(8'h0f, 8'he2, 8'hff, 1'b1);
        wr(8'h00, 8'he1, 8'h00);
        rd(8'h0f, 8'he1, 8'hfd, 1'b1);
        rd(8'h00, 8'he2, 8'h00, 1'b0);
        rd(8'h0f, 8'he3, 8'h00, 1'b0);
        $display("register test done");
        apply(8'hfd, 8'hfe, 16'h0000, 1'b1);
        crossbar_global_enable_i = 1'b1;
        for (i = 0; i < 8; i++) begin
            apply(8'h01 << i & 8'hfd, 8'h00, 16'h0000, i[0]);
            apply(8'h00, 8'h01 << i & 8'hfe, 16'h0000, 1'b0);
            apply(8'h00, 8'(i << 2), 16'h0000, 1'b0);
        end
        apply(8'h04, 8'h0c, 16'h0026, 1'b1);
        $display("corner test done");
        for (i = 0; i < 300; i++) begin
            periph_oe_i = $random(seed);
            apply($random(seed) & 8'hfd, $random(seed) & 8'hfe, $random(seed), $random(seed));
        end
        $display("random test done");
        end_sim();
    end
endmodule
`default_nettype wire
